// File: hw/watchdog_unit_pkg.sv
// Package of register map, field layout and timing constants for the watchdog unit
package watchdog_unit_pkg;

  // ************************************************************
  // Register indexes; the byte address is four times the index
  // ************************************************************
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_WINDOW_CONTROL = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_UNLOCK = 4'h4;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int POS_CHANGE_EN = 0;
  localparam int POS_ENABLE = 1;
  localparam int POS_PERIOD_LO = 2;
  localparam int POS_PERIOD_HI = 5;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [3:0] RESET_PERIOD = 4'h0;

  // ************************************************************
  // Period coding
  // ************************************************************
  localparam logic [3:0] PERIOD_FIRST_RESERVED = 4'hb;
  localparam logic [13:0] PERIOD_BASE_TICKS = 14'h0008;
  localparam int TICK_CNT_WIDTH = 14;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_WINDOW_CYCLES = 16;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CLOSED = 2'b01,
    PH_OPEN = 2'b10
  } phase_t;

endpackage

// File: hw/windowed_watchdog_timer.sv
// Windowed watchdog timer with protected configuration behind an AHB-Lite slave
// How it works
// [RL1] see: enabled watchdog resets the system when the period runs out without restart
// [RL2] see: each restart clears the count and starts a fresh period
// [RL3] see: normal mode accepts a restart at any time without penalty
// [RL4] see: window mode restart inside the closed period fires a reset instead
// [RL5] see: open period starts when closed period ends; total is their sum
// [RL6] see: in window mode the timeout field sets the open period length
// [RL7] see: counter advances on the 1 kHz tick, not on the CPU clock
// [RL8] see: enabled counter runs in every power mode, independent of system clocks; here the counter is clocked by clk_sys and only samples tick1k
// [RL9] see: codes 0 to 10 give 8 doubling to 8192 ticks
// [RL10] see: codes 11 to 15 never time out
// [RL11] see: period and enable change only when change-enable is written as one
// [RL12] see: control writes take effect only inside the timed unlock window
// [RL13] see: lock fuse makes every control register bit read-only
// [RL14] see: locked keeps closed period frozen but window enable writable
// [RL15] see: settings survive the system reset the watchdog itself issues
// [RL16] see: power-on loads period and enable from fuses, change-enable clears
// [RL17] see: enable bit starts and stops the watchdog under a proper write
// [RL18] see: control bits 7 and 6 read as zero
// [RL19] see: window control holds closed period, window enable and its change-enable
// [RL20] see: busy flag stands from a control write until the tick side takes it
// [RL21] see: reset pulse lasts one to two cycles of 2 MHz
// [RL22] see: restart is carried to the tick side before clearing or checking
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer #(
  parameter logic [7:0] UNLOCK_KEY = 8'h5a
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic tick1k,
  input wire logic restartReq,
  input wire logic [3:0] periodFuses,
  input wire logic enableFuse,
  input wire logic [3:0] closedWindowFuses,
  input wire logic lockFuse,
  output logic wdtReset
);

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic wrPend_q;
  logic [3:0] wrIdx_q;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  wire logic addrPhase = hsel && hready && htrans[1];
  wire logic [3:0] addrIdx = haddr[5:2];
  wire logic addrMapped = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'b00);
  wire logic [7:0] wrByte = hwdata[7:0];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 4'h0;
      rdData_q <= 32'h0;
    end else begin
      wrPend_q <= addrPhase && hwrite && addrMapped;
      wrIdx_q <= addrIdx;
      rdData_q <= rdData_d;
    end
  end

  // ************************************************************
  // Configuration registers on the bus side
  // ************************************************************
  logic loaded_q;
  logic locked_q;
  logic [3:0] per_q;
  logic en_q;
  logic cen_q;
  logic [3:0] closed_window_field_q;
  logic wen_q;
  logic window_change_enable_q;
  logic busy_q;
  logic [4:0] unlockCnt_q;

  wire logic unlocked = (unlockCnt_q != 5'h0);
  wire logic wrCtrl = wrPend_q && (wrIdx_q == watchdog_unit_pkg::IDX_CONTROL);
  wire logic wrWin = wrPend_q && (wrIdx_q == watchdog_unit_pkg::IDX_WINDOW_CONTROL);
  wire logic wrKey = wrPend_q && (wrIdx_q == watchdog_unit_pkg::IDX_UNLOCK) && (wrByte == UNLOCK_KEY);
  // Outside the unlock window a control or window write is dropped whole; under the lock fuse so is a control write
  wire logic ctrlAccept = wrCtrl && unlocked && !locked_q && loaded_q; // see [RL12] see [RL13]
  wire logic winAccept = wrWin && unlocked && loaded_q; // see [RL12]
  wire logic ctrlCommit = ctrlAccept && wrByte[watchdog_unit_pkg::POS_CHANGE_EN]; // see [RL11]
  wire logic winCommit = winAccept && wrByte[watchdog_unit_pkg::POS_CHANGE_EN]; // see [RL19]
  wire logic [3:0] wrPeriod = wrByte[watchdog_unit_pkg::POS_PERIOD_HI:watchdog_unit_pkg::POS_PERIOD_LO];

  // Crossing state shared with the tick side
  logic actEn_q;
  logic [3:0] actPer_q;
  logic actWen_q;
  logic [3:0] actWper_q;
  wire logic syncNow = tick1k && busy_q && (actEn_q || en_q); // see [RL20]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loaded_q <= 1'b0;
      locked_q <= 1'b0;
      per_q <= watchdog_unit_pkg::RESET_PERIOD;
      en_q <= 1'b0;
      cen_q <= 1'b0;
      closed_window_field_q <= watchdog_unit_pkg::RESET_PERIOD;
      wen_q <= 1'b0;
      window_change_enable_q <= 1'b0;
    end else if (!loaded_q) begin
      // Fuses are caught one edge after release, never under the reset itself
      loaded_q <= 1'b1;
      locked_q <= lockFuse;
      per_q <= periodFuses; // see [RL16]
      en_q <= enableFuse; // see [RL16]
      closed_window_field_q <= closedWindowFuses;
    end else begin
      if (ctrlAccept) begin
        cen_q <= wrByte[watchdog_unit_pkg::POS_CHANGE_EN];
      end
      if (ctrlCommit) begin
        per_q <= wrPeriod; // see [RL11]
        en_q <= wrByte[watchdog_unit_pkg::POS_ENABLE]; // see [RL17]
      end
      if (winAccept) begin
        window_change_enable_q <= wrByte[watchdog_unit_pkg::POS_CHANGE_EN];
      end
      if (winCommit) begin
        wen_q <= wrByte[watchdog_unit_pkg::POS_ENABLE]; // see [RL14]
        if (!locked_q) begin
          closed_window_field_q <= wrPeriod; // see [RL14]
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      unlockCnt_q <= 5'h0;
    end else begin
      // A fresh write in the crossing cycle keeps the flag up
      busy_q <= ctrlCommit || winCommit || (busy_q && !syncNow); // see [RL20]
      if (wrKey) begin
        unlockCnt_q <= 5'(watchdog_unit_pkg::UNLOCK_WINDOW_CYCLES);
      end else if (ctrlAccept || winAccept) begin
        unlockCnt_q <= 5'h0;
      end else if (unlocked) begin
        unlockCnt_q <= unlockCnt_q - 5'h1;
      end
    end
  end

  wire logic [7:0] ctrlRead = {2'b00, per_q, en_q, cen_q}; // see [RL18]
  wire logic [7:0] winRead = {2'b00, closed_window_field_q, wen_q, window_change_enable_q};
  always_comb begin
    rdData_d = 32'h0;
    if (addrPhase && !hwrite && addrMapped) begin
      unique case (addrIdx)
        watchdog_unit_pkg::IDX_CONTROL: rdData_d = {24'h0, ctrlRead};
        watchdog_unit_pkg::IDX_WINDOW_CONTROL: rdData_d = {24'h0, winRead};
        watchdog_unit_pkg::IDX_STATUS: rdData_d = {31'h0, busy_q};
        watchdog_unit_pkg::IDX_UNLOCK: rdData_d = {31'h0, unlocked};
        default: rdData_d = 32'h0;
      endcase
    end
  end

  // ************************************************************
  // Tick side: counter, window phases and reset pulse
  // ************************************************************
  logic restartPend_q;
  logic [watchdog_unit_pkg::TICK_CNT_WIDTH-1:0] cnt_q;
  watchdog_unit_pkg::phase_t phase_q;
  watchdog_unit_pkg::phase_t freshPhase;
  logic [4:0] pulseCnt_q;
  logic fire;
  logic [watchdog_unit_pkg::TICK_CNT_WIDTH-1:0] cnt_d;
  watchdog_unit_pkg::phase_t phase_d;

  // A restart is only seen on a tick, so a set in the tick cycle is consumed, not lost
  wire logic restartNow = restartPend_q || restartReq; // see [RL22]
  wire logic perReserved = (actPer_q >= watchdog_unit_pkg::PERIOD_FIRST_RESERVED);
  wire logic wperReserved = (actWper_q >= watchdog_unit_pkg::PERIOD_FIRST_RESERVED);
  wire logic [13:0] perLast = (watchdog_unit_pkg::PERIOD_BASE_TICKS << actPer_q) - 14'h1; // see [RL9] see [RL6]
  wire logic [13:0] wperLast = (watchdog_unit_pkg::PERIOD_BASE_TICKS << actWper_q) - 14'h1; // see [RL19]
  wire logic [13:0] cntInc = cnt_q + 14'h1;
  assign freshPhase = actWen_q ? watchdog_unit_pkg::PH_CLOSED : watchdog_unit_pkg::PH_OPEN;

  always_comb begin
    fire = 1'b0;
    cnt_d = cnt_q;
    phase_d = phase_q;
    if (!actEn_q) begin
      cnt_d = 14'h0;
      phase_d = watchdog_unit_pkg::PH_IDLE; // see [RL17]
    end else if (phase_q == watchdog_unit_pkg::PH_IDLE) begin
      cnt_d = 14'h0;
      phase_d = freshPhase;
    end else if (restartNow) begin
      // Too early in window mode is punished like too late
      fire = (phase_q == watchdog_unit_pkg::PH_CLOSED); // see [RL4]
      cnt_d = 14'h0; // see [RL2] see [RL3]
      phase_d = freshPhase;
    end else if (phase_q == watchdog_unit_pkg::PH_CLOSED) begin
      // A shortened period may leave the count beyond its end; end it at once
      if (!wperReserved && cnt_q >= wperLast) begin
        cnt_d = 14'h0;
        phase_d = watchdog_unit_pkg::PH_OPEN; // see [RL5]
      end else if (!wperReserved) begin
        cnt_d = cntInc;
      end
    end else if (!perReserved) begin
      // Greater-or-equal so a period cut short in mid-count still times out
      if (cnt_q >= perLast) begin
        fire = 1'b1; // see [RL1]
        cnt_d = 14'h0;
        phase_d = freshPhase;
      end else begin
        cnt_d = cntInc;
      end
    end
    // Reserved open period: count stays put, so no timeout ever comes; see [RL10]
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      restartPend_q <= 1'b0;
      cnt_q <= 14'h0;
      phase_q <= watchdog_unit_pkg::PH_IDLE;
    end else if (tick1k) begin
      // Only the tick advances the count, and only on a clk_sys edge; see [RL7] see [RL8]
      restartPend_q <= 1'b0;
      cnt_q <= cnt_d;
      phase_q <= phase_d;
    end else if (restartReq) begin
      restartPend_q <= 1'b1; // see [RL22]
    end
  end

  // Active copies; the reset output does not clear these, only power-on does
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      actEn_q <= 1'b0;
      actPer_q <= watchdog_unit_pkg::RESET_PERIOD;
      actWen_q <= 1'b0;
      actWper_q <= watchdog_unit_pkg::RESET_PERIOD;
    end else if (!loaded_q) begin
      actEn_q <= enableFuse;
      actPer_q <= periodFuses;
      actWper_q <= closedWindowFuses;
    end else if (syncNow) begin
      actEn_q <= en_q; // see [RL15] see [RL20]
      actPer_q <= per_q;
      actWen_q <= wen_q;
      actWper_q <= closed_window_field_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulseCnt_q <= 5'h0;
      wdtReset <= 1'b0;
    end else begin
      if (tick1k && fire) begin
        pulseCnt_q <= 5'(watchdog_unit_pkg::RESET_PULSE_CYCLES - 1); // see [RL21]
        wdtReset <= 1'b1;
      end else if (pulseCnt_q != 5'h0) begin
        pulseCnt_q <= pulseCnt_q - 5'h1;
      end else begin
        wdtReset <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_pulseLength;
    $rose(wdtReset) && pulseCnt_q == 5'h9 |-> wdtReset [*8] ##1 wdtReset ##1 wdtReset ##1 !wdtReset;
  endproperty
  a_pulseLength: assert property (p_pulseLength) else $error("reset pulse length wrong"); // see [RL21]

  property p_timeoutFires;
    tick1k && actEn_q && phase_q == watchdog_unit_pkg::PH_OPEN && !restartNow && !perReserved
      && cnt_q == perLast |=> wdtReset && cnt_q == 14'h0;
  endproperty
  a_timeoutFires: assert property (p_timeoutFires) else $error("timeout did not reset"); // see [RL1]

  property p_restartClears;
    tick1k && actEn_q && restartNow && phase_q == watchdog_unit_pkg::PH_OPEN |=> cnt_q == 14'h0 && !$rose(wdtReset);
  endproperty
  a_restartClears: assert property (p_restartClears) else $error("restart did not clear"); // see [RL2] see [RL3]

  property p_closedRestartFires;
    tick1k && actEn_q && restartNow && phase_q == watchdog_unit_pkg::PH_CLOSED |=> wdtReset;
  endproperty
  a_closedRestartFires: assert property (p_closedRestartFires) else $error("early restart not punished"); // see [RL4]

  property p_openFollowsClosed;
    tick1k && actEn_q && !restartNow && phase_q == watchdog_unit_pkg::PH_CLOSED && !wperReserved
      && cnt_q == wperLast |=> phase_q == watchdog_unit_pkg::PH_OPEN && !$rose(wdtReset);
  endproperty
  a_openFollowsClosed: assert property (p_openFollowsClosed) else $error("open period did not follow"); // see [RL5]

  property p_reservedSilent;
    tick1k && phase_q == watchdog_unit_pkg::PH_OPEN && perReserved && !restartNow |=> !$rose(wdtReset);
  endproperty
  a_reservedSilent: assert property (p_reservedSilent) else $error("reserved period timed out"); // see [RL10]

  property p_lockedControl;
    locked_q && loaded_q |=> $stable(per_q) && $stable(en_q) && $stable(cen_q) && $stable(closed_window_field_q);
  endproperty
  a_lockedControl: assert property (p_lockedControl) else $error("locked field changed"); // see [RL13] see [RL14]

  property p_noChangeEnable;
    wrCtrl && !wrByte[watchdog_unit_pkg::POS_CHANGE_EN] |=> $stable(per_q) && $stable(en_q);
  endproperty
  a_noChangeEnable: assert property (p_noChangeEnable) else $error("change without change-enable"); // see [RL11]

  property p_protectedWrite;
    (wrCtrl || wrWin) && !unlocked |=> $stable(per_q) && $stable(wen_q) && $stable(closed_window_field_q) && !$rose(busy_q);
  endproperty
  a_protectedWrite: assert property (p_protectedWrite) else $error("unprotected write took effect"); // see [RL12]

  property p_busyOnWrite;
    ctrlCommit || winCommit |=> busy_q;
  endproperty
  a_busyOnWrite: assert property (p_busyOnWrite) else $error("busy not raised"); // see [RL20]

  property p_reservedBitsZero;
    addrPhase && !hwrite && addrMapped && addrIdx == watchdog_unit_pkg::IDX_CONTROL |=> hrdata[7:6] == 2'b00;
  endproperty
  a_reservedBitsZero: assert property (p_reservedBitsZero) else $error("reserved bits not zero"); // see [RL18]

endmodule
`default_nettype wire

// File: tb/cpu_model.sv
// CPU side model: AHB-Lite master for register access and source of restart instructions
`timescale 1ns/100ps
`default_nettype none
module cpu_model #(
  parameter logic [7:0] KEY = 8'h5a
) (
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic tick1k,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic restartReq
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    restartReq = 1'b0;
  end

  // ************************************************************
  // Bus cycles
  // ************************************************************
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    // Data lines carry junk outside a data phase
    hwdata <= ~hwdata;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic prot(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, {26'h0, watchdog_unit_pkg::IDX_UNLOCK, 2'b00}, KEY, q);
    xfer(1'b1, a, d, q);
  endtask

  // Restart is issued just after a tick so it never coincides with one
  task automatic restart();
    do @(posedge clk_sys); while (tick1k !== 1'b1);
    restartReq <= 1'b1;
    @(posedge clk_sys);
    restartReq <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/windowed_watchdog_timer_tb.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_tb;
  localparam int LIMIT = 60000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, tick1k, restartReq, enableFuse, lockFuse, wdtReset;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] periodFuses, closedWindowFuses;
  logic [1:0] tickDiv = 2'd0;
  int seed = 32'h74af1417;
  int ticks = 0;
  int rstEdges = 0;
  int cycles = 0;
  int miscompares = 0;
  int nChecks = 0;

  windowed_watchdog_timer i_windowed_watchdog_timer (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tick1k(tick1k), .restartReq(restartReq),
    .periodFuses(periodFuses), .enableFuse(enableFuse), .closedWindowFuses(closedWindowFuses),
    .lockFuse(lockFuse), .wdtReset(wdtReset));
  cpu_model i_cpu_model (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .tick1k(tick1k),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .restartReq(restartReq));

  always #25 clk_sys = ~clk_sys;

  // Tick is sped up to one per four cycles so long periods stay affordable
  always @(posedge clk_sys) begin
    tickDiv <= tickDiv + 2'd1;
    tick1k <= (tickDiv == 2'd2);
    if (tick1k === 1'b1) ticks <= ticks + 1;
    if (wdtReset === 1'b1) rstEdges <= rstEdges + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] ctrl(input logic [3:0] timeout_period_field, input logic en, input logic change_enable_bit);
    return {2'b00, timeout_period_field, en, change_enable_bit};
  endfunction

  function automatic logic [31:0] addr(input logic [3:0] idx);
    return {26'h0, idx, 2'b00};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_check(input logic [3:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] q;
    i_cpu_model.xfer(1'b0, addr(idx), 8'h0, q);
    check(what, exp, q);
  endtask

  task automatic pw(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] q;
    i_cpu_model.prot(addr(idx), d);
    for (int i = 0; i < 20; i++) begin
      i_cpu_model.xfer(1'b0, addr(watchdog_unit_pkg::IDX_STATUS), 8'h0, q);
      if (q[0] === 1'b0) break;
    end
    check("busy", 32'h0, q);
  endtask

  task automatic wait_ticks(input int n);
    int t;
    t = ticks;
    while (ticks < t + n) @(posedge clk_sys);
  endtask

  task automatic noreset(input int n);
    int r;
    // A pulse still running from an earlier event must not count against this window
    while (wdtReset === 1'b1) @(posedge clk_sys);
    r = rstEdges;
    wait_ticks(n);
    check("reset count", r, rstEdges);
  endtask

  // Ticks from restart until reset shows, and reset pulse length in cycles
  task automatic measure(output int n, output int w);
    int t0;
    while (wdtReset === 1'b1) @(posedge clk_sys);
    i_cpu_model.restart();
    t0 = ticks;
    while (wdtReset !== 1'b1) @(posedge clk_sys);
    n = ticks - t0;
    w = 0;
    while (wdtReset === 1'b1) begin
      w++;
      @(posedge clk_sys);
    end
  endtask

  task automatic do_reset(input logic lock);
    @(posedge clk_sys);
    resetn <= 1'b0;
    lockFuse <= lock;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [31:0] q;
    logic [3:0] p;
    int n;
    int w;
    tick1k = 1'b0;
    enableFuse = 1'b1;
    lockFuse = 1'b0;
    periodFuses = 4'($unsigned($random(seed)) % 3);
    closedWindowFuses = 4'($unsigned($random(seed)) % 3);
    do_reset(1'b0);
    rd_check(watchdog_unit_pkg::IDX_CONTROL, ctrl(periodFuses, 1'b1, 1'b0), "control");
    rd_check(4'h3, 32'h0, "unmapped");
    i_cpu_model.xfer(1'b1, addr(watchdog_unit_pkg::IDX_CONTROL), ctrl(4'h3, 1'b0, 1'b1), q);
    rd_check(watchdog_unit_pkg::IDX_CONTROL, ctrl(periodFuses, 1'b1, 1'b0), "unprotected");
    pw(watchdog_unit_pkg::IDX_CONTROL, ctrl(4'h3, 1'b0, 1'b0));
    rd_check(watchdog_unit_pkg::IDX_CONTROL, ctrl(periodFuses, 1'b1, 1'b0), "no change enable");
    for (int i = 0; i < 4; i++) begin
      p = (i == 3) ? 4'ha : 4'($unsigned($random(seed)) % 4);
      i_cpu_model.restart();
      pw(watchdog_unit_pkg::IDX_CONTROL, ctrl(p, 1'b1, 1'b1));
      rd_check(watchdog_unit_pkg::IDX_CONTROL, ctrl(p, 1'b1, 1'b1), "control");
      measure(n, w);
      check("timeout ticks", (32'h8 << p) + 32'h1, n);
      check("pulse cycles", watchdog_unit_pkg::RESET_PULSE_CYCLES, w);
      rd_check(watchdog_unit_pkg::IDX_CONTROL, ctrl(p, 1'b1, 1'b1), "after reset");
    end
    i_cpu_model.restart();
    pw(watchdog_unit_pkg::IDX_CONTROL, ctrl(4'h0, 1'b1, 1'b1));
    n = rstEdges;
    for (int i = 0; i < 12; i++) begin
      wait_ticks(1 + ($unsigned($random(seed)) % 4));
      i_cpu_model.restart();
    end
    check("restart any time", n, rstEdges);
    i_cpu_model.restart();
    pw(watchdog_unit_pkg::IDX_CONTROL, ctrl(4'hb, 1'b1, 1'b1));
    noreset(100);
    pw(watchdog_unit_pkg::IDX_CONTROL, ctrl(4'h0, 1'b1, 1'b1));
    pw(watchdog_unit_pkg::IDX_WINDOW_CONTROL, ctrl(4'h1, 1'b1, 1'b1));
    measure(n, w);
    check("window ticks", 32'd25, n);
    i_cpu_model.restart();
    wait_ticks(3);
    measure(n, w);
    check("early restart", 32'd1, n);
    pw(watchdog_unit_pkg::IDX_WINDOW_CONTROL, ctrl(4'h1, 1'b0, 1'b1));
    i_cpu_model.restart();
    pw(watchdog_unit_pkg::IDX_CONTROL, ctrl(4'h0, 1'b0, 1'b1));
    noreset(40);
    i_cpu_model.prot(addr(watchdog_unit_pkg::IDX_WINDOW_CONTROL), ctrl(4'h1, 1'b0, 1'b1));
    wait_ticks(10);
    rd_check(watchdog_unit_pkg::IDX_STATUS, 32'h1, "busy while disabled");
    do_reset(1'b1);
    i_cpu_model.prot(addr(watchdog_unit_pkg::IDX_CONTROL), ctrl(4'h5, 1'b0, 1'b1));
    wait_ticks(2);
    rd_check(watchdog_unit_pkg::IDX_CONTROL, ctrl(periodFuses, 1'b1, 1'b0), "locked control");
    pw(watchdog_unit_pkg::IDX_WINDOW_CONTROL, ctrl(4'h7, 1'b1, 1'b1));
    rd_check(watchdog_unit_pkg::IDX_WINDOW_CONTROL, ctrl(closedWindowFuses, 1'b1, 1'b1), "locked window");
    report_and_stop();
  end
endmodule
`default_nettype wire
